// ===== hdl/hbp_host_pins.sv
// host bus pin front end: straps, strobes, latch, select and power-down
`timescale 1ns/10ps
`include "hbp_map.svh"
// Contract
// R1 - without config memory, width strap low gives 8-bit, high 16-bit; 32-bit ignores it
// R2 - host drives sync direction high for write, low for read; device decodes it
// R3 - address decode happens only while the address qualifier is low
// R4 - async write data accepted only while the write strobe is low
// R5 - address bits 15..1 and qualifier captured on latch strobe rising edge
// R6 - chip powered down while power-down input low, normal while high
// R7 - host holds hardware reset low at least 10 ms after stable supply
// R8 - local select asserted when qualifier low and address 15..4 match base high byte
// R9 - async read data driven only while the read strobe is low
// R10 - bus-mode strap low selects synchronous mode, high selects asynchronous or burst
// R11 - straps sampled during reset and held until the next reset; here they are caught on the first clock after reset release
module hbp_host_pins #(
  parameter int WIDE32 = 0
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_N_I,
  // straps
  input wire logic CFG_MEM_ENABLE_STRAP_I,
  input wire logic CFG_MEM_DATA_IN_WIDTH_STRAP_I,
  input wire logic BUS_MODE_STRAP_I,
  // host bus pins
  input wire logic [14:0] ADDR_I,
  input wire logic ADDR_QUALIFIER_N_I,
  input wire logic ADDR_LATCH_STROBE_N_I,
  input wire logic ASYNC_WRITE_STROBE_N_I,
  input wire logic ASYNC_READ_STROBE_N_I,
  input wire logic SYNC_WRITE_READ_DIR_I,
  input wire logic SYNC_CYCLE_I,
  input wire logic LATCH_ENABLE_I,
  input wire logic CHIP_POWERDOWN_N_I,
  // configuration
  input wire logic [7:0] BASE_HIGH_I,
  // status
  output logic [1:0] BUS_WIDTH_O,
  output logic BUS_MODE_O,
  output logic LOCAL_SELECT_N_O,
  output logic WRITE_ACCEPT_O,
  output logic READ_DRIVE_O,
  output logic POWERED_DOWN_O,
  output logic [14:0] LATCHED_ADDR_O,
  output logic LATCHED_QUAL_N_O
);
  // ---------------------------------------------
  // strap capture
  // ---------------------------------------------
  // straps sit in flops that load once, on the first clock after reset release; async reset loads constants only
  logic [1:0] width_r, width_nxt;
  logic mode_r, mode_nxt;
  logic in_rst_r;
  always_comb begin
    width_nxt = width_r;
    mode_nxt = mode_r;
    if (in_rst_r) begin // R11
      if (WIDE32 != 0) begin
        width_nxt = 2'(hbp_pkg::HBP_W32); // R1
      end else if (!CFG_MEM_ENABLE_STRAP_I) begin
        width_nxt = CFG_MEM_DATA_IN_WIDTH_STRAP_I ? 2'(hbp_pkg::HBP_W16)
                                                  : 2'(hbp_pkg::HBP_W8); // R1
      end
      mode_nxt = BUS_MODE_STRAP_I; // R10
    end
  end
  // in_rst_r stays high for the first cycle after release, catching the straps then
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      in_rst_r <= 1'b1;
      width_r <= 2'(hbp_pkg::HBP_W8);
      mode_r <= 1'b0;
    end else begin
      in_rst_r <= 1'b0;
      width_r <= width_nxt;
      mode_r <= mode_nxt;
    end
  end
  // ---------------------------------------------
  // address latch
  // ---------------------------------------------
  // strobe idles high and ads_d_r resets high, so release never looks like a latch edge
  hbp_pkg::hbp_addr_t lat_r, lat_nxt;
  logic ads_d_r, ads_d_nxt;
  always_comb begin
    lat_nxt = lat_r;
    ads_d_nxt = ADDR_LATCH_STROBE_N_I;
    if (!ads_d_r && ADDR_LATCH_STROBE_N_I) begin // R5
      lat_nxt.addr = ADDR_I;
      lat_nxt.qual_n = ADDR_QUALIFIER_N_I;
    end
  end
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      lat_r <= hbp_pkg::hbp_addr_t'{addr: 15'h0000, qual_n: 1'b1};
      ads_d_r <= 1'b1;
    end else begin
      lat_r <= lat_nxt;
      ads_d_r <= ads_d_nxt;
    end
  end
  // ---------------------------------------------
  // select decode
  // ---------------------------------------------
  // flop on the select output adds one cycle to the pin decode; the host must allow for it
  // low nibble of the compare is zero, so the base sits on a 256-byte boundary
  hbp_pkg::hbp_addr_t cur;
  logic sel_n_r, sel_n_nxt;
  always_comb begin
    cur.addr = LATCH_ENABLE_I ? lat_r.addr : ADDR_I; // R5
    cur.qual_n = LATCH_ENABLE_I ? lat_r.qual_n : ADDR_QUALIFIER_N_I; // R3 R5
    sel_n_nxt = !(!cur.qual_n && cur.addr[14:`HBP_DEC_LSB] == {BASE_HIGH_I, 4'h0}); // R3 R8
  end
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      sel_n_r <= 1'b1;
    end else begin
      sel_n_r <= sel_n_nxt;
    end
  end
  // ---------------------------------------------
  // access decode
  // ---------------------------------------------
  // strobes are read as levels; a strobe held across cycles keeps the access standing
  hbp_pkg::hbp_acc_t acc_r, acc_nxt;
  always_comb begin
    acc_nxt.wr = 1'b0;
    acc_nxt.rd = 1'b0;
    if (!sel_n_nxt && CHIP_POWERDOWN_N_I) begin // R6
      if (mode_r == 1'b0 && SYNC_CYCLE_I) begin
        acc_nxt.wr = SYNC_WRITE_READ_DIR_I; // R2
        acc_nxt.rd = !SYNC_WRITE_READ_DIR_I; // R2
      end else if (mode_r) begin
        acc_nxt.wr = !ASYNC_WRITE_STROBE_N_I; // R4
        acc_nxt.rd = !ASYNC_READ_STROBE_N_I; // R9
      end
    end
  end
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      acc_r <= hbp_pkg::hbp_acc_t'{wr: 1'b0, rd: 1'b0};
    end else begin
      acc_r <= acc_nxt;
    end
  end
  // ---------------------------------------------
  // power-down
  // ---------------------------------------------
  // only flagged here; stopping clocks is left to the logic around this block
  logic pd_r, pd_nxt;
  always_comb begin
    pd_nxt = !CHIP_POWERDOWN_N_I; // R6
  end
  always_ff @(posedge CLOCK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      pd_r <= 1'b0;
    end else begin
      pd_r <= pd_nxt;
    end
  end
  // ---------------------------------------------
  // outputs
  // ---------------------------------------------
  assign BUS_WIDTH_O = width_r;
  assign BUS_MODE_O = mode_r;
  assign LOCAL_SELECT_N_O = sel_n_r;
  assign WRITE_ACCEPT_O = acc_r.wr;
  assign READ_DRIVE_O = acc_r.rd;
  assign POWERED_DOWN_O = pd_r;
  assign LATCHED_ADDR_O = lat_r.addr;
  assign LATCHED_QUAL_N_O = lat_r.qual_n;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  strap_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R11
    !in_rst_r && !$past(in_rst_r) |-> $stable(width_r) && $stable(mode_r))
    else $error("straps changed outside reset");
  width_pick_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R1
    in_rst_r && WIDE32 == 0 && !CFG_MEM_ENABLE_STRAP_I |=>
    width_r == (CFG_MEM_DATA_IN_WIDTH_STRAP_I ? 2'd1 : 2'd0))
    else $error("bus width strap wrong");
  qual_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R3
    !LATCH_ENABLE_I && ADDR_QUALIFIER_N_I |=> LOCAL_SELECT_N_O)
    else $error("select without qualifier");
  select_match_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R8
    !LATCH_ENABLE_I && !ADDR_QUALIFIER_N_I && ADDR_I[14:3] == {BASE_HIGH_I, 4'h0}
    |=> !LOCAL_SELECT_N_O)
    else $error("select missed a match");
  write_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R4
    mode_r && ASYNC_WRITE_STROBE_N_I |=> !WRITE_ACCEPT_O)
    else $error("write taken without strobe");
  read_gate_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R9
    mode_r && ASYNC_READ_STROBE_N_I |=> !READ_DRIVE_O)
    else $error("read driven without strobe");
  sync_dir_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R2
    WRITE_ACCEPT_O && !mode_r |-> $past(SYNC_WRITE_READ_DIR_I))
    else $error("sync write with read direction");
  latch_edge_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R5
    !ads_d_r && ADDR_LATCH_STROBE_N_I |=> LATCHED_ADDR_O == $past(ADDR_I))
    else $error("address not latched on strobe rise");
  power_down_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R6
    !CHIP_POWERDOWN_N_I |=> POWERED_DOWN_O && !WRITE_ACCEPT_O)
    else $error("power-down not honoured");
  mode_pick_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R10
    in_rst_r |=> mode_r == $past(BUS_MODE_STRAP_I))
    else $error("bus mode strap wrong");
  width_keep_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R1
    in_rst_r && WIDE32 == 0 && CFG_MEM_ENABLE_STRAP_I |=> width_r == 2'd0)
    else $error("width changed with config memory fitted");
  latch_sel_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R5
    LATCH_ENABLE_I && LATCHED_QUAL_N_O |=> LOCAL_SELECT_N_O)
    else $error("select without latched qualifier");
  latch_qual_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R5
    !ads_d_r && ADDR_LATCH_STROBE_N_I |=> LATCHED_QUAL_N_O == $past(ADDR_QUALIFIER_N_I))
    else $error("qualifier not latched on strobe rise");
  latch_hold_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R5
    !(!ads_d_r && ADDR_LATCH_STROBE_N_I) |=> $stable(LATCHED_ADDR_O) && $stable(LATCHED_QUAL_N_O))
    else $error("latch moved without strobe rise");
  pd_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R6
    !CHIP_POWERDOWN_N_I |=> !READ_DRIVE_O)
    else $error("read driven in power-down");
  pd_wake_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R6
    CHIP_POWERDOWN_N_I |=> !POWERED_DOWN_O)
    else $error("power-down flag stuck");
  sync_read_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R2
    READ_DRIVE_O && !mode_r |-> !$past(SYNC_WRITE_READ_DIR_I))
    else $error("sync read with write direction");
  sync_idle_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R2
    !mode_r && !SYNC_CYCLE_I |=> !WRITE_ACCEPT_O && !READ_DRIVE_O)
    else $error("sync access outside a cycle");
  desel_quiet_a: assert property (@(posedge CLOCK_I) disable iff (!RST_N_I) // R8
    LOCAL_SELECT_N_O |-> !WRITE_ACCEPT_O && !READ_DRIVE_O)
    else $error("access while not selected");
endmodule // hbp_host_pins

// ===== hdl/hbp_map.svh
// constants for the host bus pin front end
`ifndef HBP_MAP_SVH
`define HBP_MAP_SVH
`define HBP_RESET_TIME_MS 10
`define HBP_CLOCK_MHZ 125
`define HBP_RESET_CYCLES (`HBP_RESET_TIME_MS * 1000 * `HBP_CLOCK_MHZ)
`define HBP_ADDR_W 15
`define HBP_DEC_LSB 3
`define HBP_BASE_RST 8'h00
`endif

// ===== hdl/hbp_pkg.sv
// types for the host bus pin front end
package hbp_pkg;
  typedef enum logic [1:0] {
    HBP_W8,
    HBP_W16,
    HBP_W32
  } hbp_width_t;
  typedef enum logic [1:0] {
    HBP_SYNC,
    HBP_ASYNC
  } hbp_mode_t;
  typedef struct packed {
    logic [14:0] addr;
    logic qual_n;
  } hbp_addr_t;
  typedef struct packed {
    logic wr;
    logic rd;
  } hbp_acc_t;
endpackage

// ===== test/hbp_host_model.sv
// host model driving the bus pins of the front end
`timescale 1ns/10ps
module hbp_host_model (
  // clock
  input wire logic clk_i,
  // bus pins
  output hbp_pkg::hbp_addr_t a_o,
  output logic [4:0] ctl_o
);
  // ctl_o is {latch strobe, write strobe, read strobe, direction, sync cycle}
  initial begin
    a_o = '{addr: 15'h0, qual_n: 1'b1};
    ctl_o = 5'h1c;
  end
  // one request, changed just after an edge and held until the next call
  task automatic drive(input logic [14:0] ad, input logic q, input logic [4:0] c);
    @(posedge clk_i);
    a_o <= '{addr: ad, qual_n: q};
    ctl_o <= c;
  endtask
  // released address shows its inverse so a stale match cannot pass
  task automatic idle;
    @(posedge clk_i);
    a_o <= '{addr: ~a_o.addr, qual_n: 1'b1};
    ctl_o <= 5'h1c;
  endtask
endmodule // hbp_host_model

// ===== test/testbench.sv
// self-checking bench for the host bus pin front end
`timescale 1ns/10ps
module testbench;
  logic clk = 0, rst_n = 0, cfg_en = 0, w_s = 1, m_s = 1, le = 0, pd_n = 1;
  logic sel_n, wacc, rdrv, pdo, mode, lq;
  logic [1:0] wid;
  logic [14:0] la;
  logic [7:0] base = 8'h5a;
  logic [4:0] c;
  hbp_pkg::hbp_addr_t a;
  int failures = 0, compares = 0, cyc = 0;
  always #4 clk = ~clk;
  hbp_host_model i_host (.clk_i(clk), .a_o(a), .ctl_o(c));
  hbp_host_pins i_dut (.CLOCK_I(clk), .RST_N_I(rst_n), .CFG_MEM_ENABLE_STRAP_I(cfg_en),
    .CFG_MEM_DATA_IN_WIDTH_STRAP_I(w_s), .BUS_MODE_STRAP_I(m_s), .ADDR_I(a.addr),
    .ADDR_QUALIFIER_N_I(a.qual_n), .ADDR_LATCH_STROBE_N_I(c[4]), .ASYNC_WRITE_STROBE_N_I(c[3]),
    .ASYNC_READ_STROBE_N_I(c[2]), .SYNC_WRITE_READ_DIR_I(c[1]), .SYNC_CYCLE_I(c[0]),
    .LATCH_ENABLE_I(le), .CHIP_POWERDOWN_N_I(pd_n), .BASE_HIGH_I(base), .BUS_WIDTH_O(wid),
    .BUS_MODE_O(mode), .LOCAL_SELECT_N_O(sel_n), .WRITE_ACCEPT_O(wacc), .READ_DRIVE_O(rdrv),
    .POWERED_DOWN_O(pdo), .LATCHED_ADDR_O(la), .LATCHED_QUAL_N_O(lq));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    compares++;
    if (s !== e) begin
      failures++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic conclude;
    if (failures == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // the run needs under a hundred cycles; far above that means a hang
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      failures++;
      conclude();
    end
  end
  task automatic go(input logic [14:0] ad, input logic q, input logic [4:0] k,
                    input logic [2:0] e);
    i_host.drive(ad, q, k);
    @(negedge clk);
    @(negedge clk);
    chk({sel_n, wacc, rdrv}, e);
  endtask
  // far shorter than the real reset time; the front end does not time it
  task automatic rst(input logic e, input logic w, input logic m, input logic [1:0] ew);
    i_host.idle();
    rst_n <= 0;
    cfg_en <= e;
    w_s <= w;
    m_s <= m;
    repeat (6) @(posedge clk);
    rst_n <= 1;
    repeat (2) @(posedge clk);
    w_s <= ~w;
    m_s <= ~m;
    repeat (2) @(negedge clk);
    chk({wid, mode}, {ew, m});
  endtask
  initial begin
    rst(1'b0, 1'b1, 1'b1, hbp_pkg::HBP_W16);
    go(15'h2d05, 1'b0, 5'h14, 3'b010);
    go(15'h2d05, 1'b0, 5'h18, 3'b001);
    go(15'h2d05, 1'b1, 5'h14, 3'b100);
    go(15'h2d08, 1'b0, 5'h14, 3'b100);
    @(posedge clk);
    base <= 8'h5b;
    go(15'h2d80, 1'b0, 5'h14, 3'b010);
    go(15'h2d05, 1'b0, 5'h14, 3'b100);
    @(posedge clk);
    base <= 8'h5a;
    le <= 1;
    go(15'h2d05, 1'b0, 5'h0c, 3'b100);
    i_host.drive(15'h2d07, 1'b0, 5'h1c);
    repeat (2) @(negedge clk);
    chk({la, lq}, {15'h2d07, 1'b0});
    go(15'h1234, 1'b1, 5'h14, 3'b010);
    chk({la, lq}, {15'h2d07, 1'b0});
    @(posedge clk);
    le <= 0;
    pd_n <= 0;
    go(15'h2d05, 1'b0, 5'h14, 3'b000);
    chk({wacc, pdo}, 2'b01);
    @(posedge clk);
    pd_n <= 1;
    go(15'h2d05, 1'b0, 5'h14, 3'b010);
    chk(pdo, 1'b0);
    rst(1'b0, 1'b0, 1'b0, hbp_pkg::HBP_W8);
    rst(1'b1, 1'b1, 1'b0, hbp_pkg::HBP_W8);
    go(15'h2d05, 1'b0, 5'h1f, 3'b010);
    go(15'h2d05, 1'b0, 5'h1d, 3'b001);
    conclude();
  end
endmodule // testbench
